// ==== core/pod_defines.svh ====
`ifndef POD_DEFINES_SVH
`define POD_DEFINES_SVH
// register byte offsets
`define POD_REG_CTRL 6'h00
`define POD_REG_AREA 6'h04
`define POD_REG_DCFG 6'h08
`define POD_REG_DSTART 6'h0c
`define POD_REG_DEND 6'h10
`define POD_REG_DCMD 6'h14
`define POD_REG_STATUS 6'h18
`define POD_REG_LOC 6'h1c
`define POD_REG_MPTR 6'h20
`define POD_REG_PRINTER_OUTPUT_POINTER 6'h24
// control, command and status bit positions
`define POD_CTRL_REQ 0
`define POD_CTRL_FMARK 1
`define POD_CTRL_PASS 2
`define POD_CMD_GO 0
`define POD_CMD_ABORT 1
`define POD_ST_REJECT 2
// stored data word fields
`define POD_W_SIGN 31
`define POD_W_HIRES 30
`define POD_W_SECS 29
`define POD_W_AEND 28
`define POD_W_FIX4 27
// ascii characters
`define POD_CH_CR 8'h0d
`define POD_CH_LF 8'h0a
`define POD_CH_SP 8'h20
`define POD_CH_PLUS 8'h2b
`define POD_CH_MINUS 8'h2d
`define POD_CH_COMMA 8'h2c
`define POD_CH_DOT 8'h2e
`define POD_CH_ZERO 4'h3
// eighths of a second as three bcd digits, entry 0 at the bottom
`define POD_FRAC_TBL 96'h875750625500375250125000
// csv digits kept per eighth, trailing zeros dropped
`define POD_FRAC_LEN 16'hedec
// misc constants
`define POD_LAST_POS 3'h7
`define POD_UNIV_ADDR 4'h1
`define POD_CODE_NEW 8'h80
`define POD_CODE_ALL 8'h81
`define POD_FILE_MARK 8'hff
`define POD_RESP_OKAY 2'h0
`define POD_RESP_SLVERR 2'h2
`endif

// ==== core/pod_dispatcher.sv ====
// Behaviour
// - decode printer codes: format digit plus baud
// - code 7N feeds storage module N, file mark
// - online codes 80/81 copy to other area
// - online data from active area, pass resets
// - busy connector queues request, serve later
// - drop duplicate device, baud, area entries
// - send up to write pointer captured at activation
// - pin printer uses addressing line as enable
// - module address 1 picks lowest present module
// - absent module: pointer kept, entry dropped
// - dump asks area unless area 2 unallocated
// - dump start/end preset from pointers, overridable
// - dump shows location, keypress aborts after block
// - dump rejects copy codes 80 and 81
// - printable point gets two-digit id and sign
// - id, day, time four characters, five for hires unless fix4
// - seconds carry one eighth resolution
// - eight points per printed line, then CR LF
// - line end: hires CR LF, lowres space CR LF
// - csv strips ids, zeros, plus; commas, CR LF
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "pod_defines.svh"
module pod_dispatcher #(
    parameter int AW = 17,
    parameter int QD = 4,
    parameter logic [3:0] PRN_ADDR = 4'h9
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [5:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [5:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // final storage
    output logic mem_rd,
    output logic [AW-1:0] mem_addr,
    input wire logic [31:0] mem_rdata,
    input wire logic [AW-1:0] wr_ptr1,
    input wire logic [AW-1:0] wr_ptr2,
    input wire logic area2_alloc,
    // serial connector
    input wire logic conn_busy,
    input wire logic [8:1] module_present,
    output logic [7:0] ser_data,
    output logic ser_valid,
    input wire logic ser_ready,
    output logic [1:0] baud_code,
    output logic addressing_enable_line,
    output logic [3:0] dev_addr,
    output logic dev_addressed,
    // area to area copy
    output logic copy_valid,
    output logic copy_whole,
    output logic copy_to_area,
    output logic [AW-1:0] copy_first,
    output logic [AW-1:0] copy_last,
    input wire logic copy_ready
);
    localparam int QW = $clog2(QD + 1);

    // every flop of the block
    typedef struct packed {
        logic aw_have;
        logic [5:0] aw_addr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] code;
        logic area;
        logic dmp_area;
        logic [7:0] dmp_code;
        logic [AW-1:0] dmp_start;
        logic [AW-1:0] dmp_end;
        logic dmp_go;
        logic abort;
        logic reject;
        logic [QD-1:0][9:0] q;
        logic [QW-1:0] qn;
        pod_pkg::pod_state_e state;
        logic [9:0] cur;
        logic dumping;
        logic [AW-1:0] loc;
        logic [AW-1:0] endp;
        logic [3:0] addr;
        logic [1:0][AW-1:0] mptr;
        logic [1:0][AW-1:0] printer_output_pointer;
        logic [1:0][AW-1:0] cptr;
        logic [127:0] pbuf;
        logic [4:0] plen;
        logic [7:0] pid;
        logic [2:0] lpos;
        logic [8:1] sy1;
        logic [8:1] sy2;
        logic copy_v;
        logic copy_whole;
        logic [AW-1:0] copy_first;
        logic [AW-1:0] copy_last;
        logic pin_en;
        logic addr_v;
    } pod_st_s;

    pod_st_s st;
    pod_st_s next_st;

    // code legality; copy codes only for online requests
    function automatic logic pod_code_ok(input logic [7:0] c, input logic online);
        if (c[7:4] >= 4'h1 && c[7:4] <= 4'h6) begin
            return c[3:0] <= 4'h3;
        end
        if (c[7:4] == 4'h7) begin
            return c[3:0] >= 4'h1 && c[3:0] <= 4'h8;
        end
        return online && (c == `POD_CODE_NEW || c == `POD_CODE_ALL);
    endfunction : pod_code_ok

    // one data point into bytes, low byte first
    function automatic logic [132:0] pod_fmt(input logic [31:0] w, input logic [7:0] id,
                                             input pod_pkg::pod_fmt_e f, input logic eol);
        logic [127:0] b;
        logic [4:0] n;
        logic [2:0] nd;
        logic lead;
        logic [3:0] dg;
        logic [11:0] fr;
        logic [1:0] fl;
        b = '0;
        n = 5'h0;
        lead = 1'b1;
        nd = (w[`POD_W_HIRES] && !w[`POD_W_FIX4]) ? 3'h5 : 3'h4;
        fr = 12'(`POD_FRAC_TBL >> (7'(w[22:20]) * 7'hc));
        fl = 2'(`POD_FRAC_LEN >> {w[22:20], 1'b0});
        if (f == pod_pkg::POD_BIN) begin
            // binary words go out untouched, msb first
            b[31:0] = {w[7:0], w[15:8], w[23:16], w[31:24]};
            n = 5'h4;
        end else begin
            if (f == pod_pkg::POD_PRT) begin
                b[{n[3:0], 3'h0} +: 8] = {`POD_CH_ZERO, id[7:4]};
                n = n + 5'h1;
                b[{n[3:0], 3'h0} +: 8] = {`POD_CH_ZERO, id[3:0]};
                n = n + 5'h1;
                b[{n[3:0], 3'h0} +: 8] = w[`POD_W_SIGN] ? `POD_CH_MINUS : `POD_CH_PLUS;
                n = n + 5'h1;
            end else if (w[`POD_W_SIGN]) begin
                // csv keeps only a minus sign
                b[{n[3:0], 3'h0} +: 8] = `POD_CH_MINUS;
                n = n + 5'h1;
            end
            for (int i = 4; i >= 0; i--) begin
                dg = w[i*4 +: 4];
                if (3'(i) < nd && (f == pod_pkg::POD_PRT || dg != 4'h0 || !lead || i == 0)) begin
                    lead = 1'b0;
                    b[{n[3:0], 3'h0} +: 8] = {`POD_CH_ZERO, dg};
                    n = n + 5'h1;
                end
            end
            if (w[`POD_W_SECS] && (f == pod_pkg::POD_PRT || fl != 2'h0)) begin
                // fraction of a second in eighths
                b[{n[3:0], 3'h0} +: 8] = `POD_CH_DOT;
                n = n + 5'h1;
                for (int i = 2; i >= 0; i--) begin
                    if (f == pod_pkg::POD_PRT || 2'(3 - i) <= fl) begin
                        b[{n[3:0], 3'h0} +: 8] = {`POD_CH_ZERO, fr[i*4 +: 4]};
                        n = n + 5'h1;
                    end
                end
            end
            if (f == pod_pkg::POD_CSV && !w[`POD_W_AEND]) begin
                b[{n[3:0], 3'h0} +: 8] = `POD_CH_COMMA;
                n = n + 5'h1;
            end else if (f == pod_pkg::POD_PRT && !eol) begin
                b[{n[3:0], 3'h0} +: 8] = `POD_CH_SP;
                n = n + 5'h1;
            end else begin
                if (f == pod_pkg::POD_PRT && !w[`POD_W_HIRES]) begin
                    b[{n[3:0], 3'h0} +: 8] = `POD_CH_SP;
                    n = n + 5'h1;
                end
                b[{n[3:0], 3'h0} +: 8] = `POD_CH_CR;
                n = n + 5'h1;
                b[{n[3:0], 3'h0} +: 8] = `POD_CH_LF;
                n = n + 5'h1;
            end
        end
        return {n, b};
    endfunction : pod_fmt

    logic [31:0] wmask;
    logic [31:0] wv;
    logic wr_fire;
    logic [9:0] ent;
    logic dup;
    logic [3:0] low_mod;
    logic da;
    logic [7:0] dcode;
    logic ea;
    pod_pkg::pod_fmt_e fmt;
    logic eol;

    // bus handshakes straight from state
    assign awready = !st.aw_have && !st.bvalid;
    assign wready = !st.w_have && !st.bvalid;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = !st.rvalid;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    // connector and storage side
    assign mem_addr = st.loc;
    assign mem_rd = st.state == pod_pkg::POD_RD && st.loc != st.endp;
    assign ser_data = st.pbuf[7:0];
    assign ser_valid = st.state == pod_pkg::POD_EMIT;
    assign baud_code = st.cur[1:0];
    assign addressing_enable_line = st.pin_en;
    assign dev_addr = st.addr;
    assign dev_addressed = st.addr_v;
    assign copy_valid = st.copy_v;
    assign copy_whole = st.copy_whole;
    assign copy_to_area = !st.cur[8];
    assign copy_first = st.copy_first;
    assign copy_last = st.copy_last;

    // next state of the whole block
    always_comb begin
        next_st = st;
        wmask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
        wv = st.wdata & wmask;
        wr_fire = st.aw_have && st.w_have && !st.bvalid;
        ent = '0;
        dup = 1'b0;
        low_mod = 4'h0;
        ea = st.cur[8];
        // storage module 1 means lowest module present
        for (int i = 8; i >= 1; i--) begin
            if (st.sy2[i]) begin
                low_mod = 4'(i);
            end
        end
        case (st.cur[7:4])
            4'h1, 4'h4: fmt = pod_pkg::POD_PRT;
            4'h2, 4'h5: fmt = pod_pkg::POD_CSV;
            default: fmt = pod_pkg::POD_BIN;
        endcase
        // in printer format the last point of a transfer closes its line as well
        eol = st.lpos == `POD_LAST_POS || mem_rdata[`POD_W_AEND]
              || st.loc + AW'(1) == st.endp;
        // module present pins, two flops before use
        next_st.sy1 = module_present;
        next_st.sy2 = st.sy1;
        // dispatcher sequence
        case (st.state)
            pod_pkg::POD_IDLE: begin
                if (st.dmp_go) begin
                    // manual dump borrows the dispatcher, presets already in place
                    next_st.dmp_go = 1'b0;
                    next_st.dumping = 1'b1;
                    next_st.cur = {1'b0, st.dmp_area, st.dmp_code};
                    next_st.loc = st.dmp_start;
                    next_st.endp = st.dmp_end;
                    next_st.state = pod_pkg::POD_ACT;
                end else if (st.qn != '0 && !conn_busy) begin
                    // oldest entry takes the connector
                    next_st.cur = st.q[0];
                    for (int i = 0; i < QD - 1; i++) begin
                        next_st.q[i] = st.q[i+1];
                    end
                    next_st.qn = st.qn - QW'(1);
                    next_st.state = pod_pkg::POD_ACT;
                end
            end
            pod_pkg::POD_ACT: begin
                next_st.pid = 8'h01;
                next_st.lpos = 3'h0;
                next_st.state = pod_pkg::POD_RD;
                if (!st.dumping) begin
                    // end point frozen now; later data waits its next turn
                    next_st.endp = ea ? wr_ptr2 : wr_ptr1;
                    next_st.loc = (st.cur[7:4] == 4'h7) ? st.mptr[ea] : st.printer_output_pointer[ea];
                end
                if (st.cur[7:0] == `POD_CODE_NEW || st.cur[7:0] == `POD_CODE_ALL) begin
                    next_st.copy_v = 1'b1;
                    next_st.copy_whole = st.cur[0];
                    next_st.copy_first = st.cur[0] ? '0 : st.cptr[ea];
                    next_st.copy_last = ea ? wr_ptr2 : wr_ptr1;
                    next_st.state = pod_pkg::POD_COPY;
                end else if (st.cur[7:4] == 4'h7) begin
                    next_st.addr = (st.cur[3:0] == `POD_UNIV_ADDR) ? low_mod : st.cur[3:0];
                    if ((st.cur[3:0] == `POD_UNIV_ADDR) ? low_mod == 4'h0
                                                        : !st.sy2[st.cur[3:0]]) begin
                        // module missing: entry dropped, pointer untouched
                        next_st.dumping = 1'b0;
                        next_st.state = pod_pkg::POD_IDLE;
                    end else begin
                        next_st.addr_v = 1'b1;
                        if (st.cur[9]) begin
                            // file mark only, no data moves
                            next_st.pbuf = {120'h0, `POD_FILE_MARK};
                            next_st.plen = 5'h1;
                            next_st.endp = st.mptr[ea];
                            next_st.loc = st.mptr[ea];
                            next_st.state = pod_pkg::POD_EMIT;
                        end
                    end
                end else if (st.cur[7:4] >= 4'h4) begin
                    next_st.pin_en = 1'b1;
                end else begin
                    next_st.addr = PRN_ADDR;
                    next_st.addr_v = 1'b1;
                end
            end
            pod_pkg::POD_RD: begin
                next_st.state = (st.loc == st.endp) ? pod_pkg::POD_FIN : pod_pkg::POD_CAP;
            end
            pod_pkg::POD_CAP: begin
                {next_st.plen, next_st.pbuf} = pod_fmt(mem_rdata, st.pid, fmt, eol);
                next_st.loc = st.loc + AW'(1);
                next_st.lpos = eol ? 3'h0 : st.lpos + 3'h1;
                if (mem_rdata[`POD_W_AEND]) begin
                    next_st.pid = 8'h01;
                end else if (st.pid[3:0] == 4'h9) begin
                    next_st.pid = {st.pid[7:4] + 4'h1, 4'h0};
                end else begin
                    next_st.pid = st.pid + 8'h01;
                end
                next_st.state = pod_pkg::POD_EMIT;
            end
            pod_pkg::POD_EMIT: begin
                if (ser_ready) begin
                    next_st.pbuf = {8'h0, st.pbuf[127:8]};
                    next_st.plen = st.plen - 5'h1;
                    if (st.plen == 5'h1) begin
                        // abort only lands between whole points
                        next_st.state = st.abort ? pod_pkg::POD_FIN : pod_pkg::POD_RD;
                    end
                end
            end
            pod_pkg::POD_FIN: begin
                if (!st.dumping) begin
                    if (st.cur[7:4] == 4'h7) begin
                        next_st.mptr[ea] = st.loc;
                    end else begin
                        next_st.printer_output_pointer[ea] = st.loc;
                    end
                end
                next_st.dumping = 1'b0;
                next_st.abort = 1'b0;
                next_st.pin_en = 1'b0;
                next_st.addr_v = 1'b0;
                next_st.state = pod_pkg::POD_IDLE;
            end
            pod_pkg::POD_COPY: begin
                if (copy_ready) begin
                    next_st.cptr[ea] = st.copy_last;
                    next_st.copy_v = 1'b0;
                    next_st.state = pod_pkg::POD_IDLE;
                end
            end
            default: begin
                next_st.state = pod_pkg::POD_IDLE;
            end
        endcase
        // bus: address and data land in either order
        if (awvalid && awready) begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_st.w_have = 1'b1;
            next_st.wdata = wdata;
            next_st.wstrb = wstrb;
        end
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        da = area2_alloc & wv[0];
        dcode = (st.dmp_code & ~wmask[15:8]) | wv[15:8];
        if (wr_fire) begin
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `POD_RESP_OKAY;
            case (st.aw_addr)
                `POD_REG_CTRL: begin
                    next_st.code = (st.code & ~wmask[15:8]) | wv[15:8];
                    ent = {wv[`POD_CTRL_FMARK], st.area, next_st.code};
                    for (int i = 0; i < QD; i++) begin
                        if (QW'(i) < next_st.qn && next_st.q[i] == ent) begin
                            dup = 1'b1;
                        end
                    end
                    if (wv[`POD_CTRL_REQ]) begin
                        if (!pod_code_ok(ent[7:0], 1'b1)) begin
                            next_st.reject = 1'b1;
                        end else if (!dup && next_st.qn != QW'(QD)) begin
                            next_st.q[next_st.qn] = ent;
                            next_st.qn = next_st.qn + QW'(1);
                        end
                    end
                    if (wv[`POD_CTRL_PASS]) begin
                        next_st.area = 1'b0;
                    end
                end
                `POD_REG_AREA: begin
                    if (st.wstrb[0]) begin
                        next_st.area = wv[0];
                    end
                end
                `POD_REG_DCFG: begin
                    // area 2 choice ignored when it has no memory
                    next_st.dmp_area = da;
                    next_st.dmp_code = dcode;
                    next_st.dmp_start = (dcode[7:4] == 4'h7) ? st.mptr[da] : st.printer_output_pointer[da];
                    next_st.dmp_end = da ? wr_ptr2 : wr_ptr1;
                    if (!pod_code_ok(dcode, 1'b0)) begin
                        next_st.reject = 1'b1;
                    end
                end
                `POD_REG_DSTART: begin
                    next_st.dmp_start = AW'((32'(st.dmp_start) & ~wmask) | wv);
                end
                `POD_REG_DEND: begin
                    next_st.dmp_end = AW'((32'(st.dmp_end) & ~wmask) | wv);
                end
                `POD_REG_DCMD: begin
                    if (wv[`POD_CMD_GO] && !st.dumping && pod_code_ok(st.dmp_code, 1'b0)) begin
                        next_st.dmp_go = 1'b1;
                    end
                    if (wv[`POD_CMD_ABORT] && st.dumping) begin
                        next_st.abort = 1'b1;
                    end
                end
                `POD_REG_STATUS: begin
                    // a reject in this same cycle survives the clear
                    if (wv[`POD_ST_REJECT] && !next_st.reject) begin
                        next_st.reject = 1'b0;
                    end else if (wv[`POD_ST_REJECT] && !st.reject) begin
                        next_st.reject = 1'b1;
                    end else if (wv[`POD_ST_REJECT]) begin
                        next_st.reject = 1'b0;
                    end
                end
                `POD_REG_LOC, `POD_REG_MPTR, `POD_REG_PRINTER_OUTPUT_POINTER: begin
                end
                default: begin
                    next_st.bresp = `POD_RESP_SLVERR;
                end
            endcase
        end
        // reads answer one cycle after the address is taken
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = `POD_RESP_OKAY;
            case (araddr)
                `POD_REG_CTRL: next_st.rdata = {16'h0, st.code, 8'h0};
                `POD_REG_AREA: next_st.rdata = {31'h0, st.area};
                `POD_REG_DCFG: next_st.rdata = {16'h0, st.dmp_code, 7'h0, st.dmp_area};
                `POD_REG_DSTART: next_st.rdata = 32'(st.dmp_start);
                `POD_REG_DEND: next_st.rdata = 32'(st.dmp_end);
                `POD_REG_DCMD: next_st.rdata = 32'h0;
                `POD_REG_STATUS: next_st.rdata = {24'h0, 4'(st.qn), 1'b0, st.reject,
                                                  st.dumping, st.state != pod_pkg::POD_IDLE};
                `POD_REG_LOC: next_st.rdata = 32'(st.loc);
                `POD_REG_MPTR: next_st.rdata = 32'(st.mptr[st.area]);
                `POD_REG_PRINTER_OUTPUT_POINTER: next_st.rdata = 32'(st.printer_output_pointer[st.area]);
                default: begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = `POD_RESP_SLVERR;
                end
            endcase
        end
    end

    // single register stage for all state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : pod_dispatcher

// ==== core/pod_pkg.sv ====
package pod_pkg;
    // dispatcher sequence, gray along idle-act-rd-cap-emit-fin
    typedef enum logic [2:0] {
        POD_IDLE = 3'h0,
        POD_ACT = 3'h1,
        POD_RD = 3'h3,
        POD_CAP = 3'h2,
        POD_EMIT = 3'h6,
        POD_FIN = 3'h7,
        POD_COPY = 3'h5
    } pod_state_e;
    // output formats
    typedef enum logic [1:0] {
        POD_PRT = 2'h0,
        POD_CSV = 2'h1,
        POD_BIN = 2'h2
    } pod_fmt_e;
endpackage : pod_pkg

// ==== tb/pod_conn_model.sv ====
`timescale 1ns/1ns
module pod_conn_model (
    // clock, pace select
    input wire logic aclk,
    input wire logic slow,
    // storage read port
    input wire logic mem_rd,
    output logic [31:0] mem_rdata,
    // connector side
    input wire logic ser_valid,
    input wire logic [7:0] ser_data,
    input wire logic addressing_enable_line,
    input wire logic dev_addressed,
    output logic ser_ready
);
    logic [7:0] q[$]; // bytes taken by an enabled peripheral
    initial begin
        mem_rdata = 32'h0;
        ser_ready = 1'h0;
    end
    // storage answers one cycle late; idle cycles show a moving pattern
    always @(posedge aclk) begin
        mem_rdata <= mem_rd ? 32'h1234 : ~mem_rdata;
        ser_ready <= slow ? ~ser_ready : 1'h1; // a slow printer stalls
        if (ser_valid && ser_ready && (addressing_enable_line || dev_addressed)) begin
            q.push_back(ser_data);
        end
    end
endmodule : pod_conn_model

// ==== tb/pod_dispatcher_props.sv ====
`timescale 1ns/1ns
module pod_dispatcher_props (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus handshakes
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic bvalid,
    input wire logic bready,
    // storage and connector
    input wire logic mem_rd,
    input wire logic ser_valid,
    input wire logic ser_ready,
    input wire logic [7:0] ser_data,
    input wire logic [1:0] baud_code,
    input wire logic addressing_enable_line,
    input wire logic dev_addressed
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a point read is one cycle, then a capture cycle with no byte out
    sequence s_cap; !mem_rd && !ser_valid; endsequence
    property p_ar; arvalid && arready |=> rvalid; endproperty
    property p_rh; rvalid && !rready |=> rvalid; endproperty
    property p_bh; bvalid && !bready |=> bvalid; endproperty
    property p_rd; mem_rd |=> s_cap; endproperty
    property p_ser; ser_valid && !ser_ready |=> ser_valid && $stable(ser_data); endproperty
    property p_own; !(addressing_enable_line && dev_addressed); endproperty
    property p_baud; addressing_enable_line ##1 addressing_enable_line |-> $stable(baud_code);
    endproperty
    property p_seq; mem_rd |-> !ser_valid; endproperty
    a_ar: assert property (p_ar) else $error("read answer late");
    a_rh: assert property (p_rh) else $error("read data dropped");
    a_bh: assert property (p_bh) else $error("write response dropped");
    a_rd: assert property (p_rd) else $error("read not followed by capture");
    a_ser: assert property (p_ser) else $error("byte changed unaccepted");
    a_own: assert property (p_own) else $error("two owners on link");
    a_baud: assert property (p_baud) else $error("baud moved in transfer");
    a_seq: assert property (p_seq) else $error("byte during read");
endmodule : pod_dispatcher_props
bind pod_dispatcher pod_dispatcher_props i_props (.*);

// ==== tb/pod_dispatcher_tb.sv ====
`timescale 1ns/1ns
`include "pod_defines.svh"
module pod_dispatcher_tb;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1;
    logic arvalid = 1'h0, rready = 1'h1, bvalid, awready, wready, arready, rvalid, mem_rd;
    logic area2_alloc = 1'h0, conn_busy = 1'h0, copy_ready = 1'h1, slow = 1'h1, ser_valid;
    logic addressing_enable_line, dev_addressed, copy_valid, copy_whole, copy_to_area, ser_ready;
    logic [5:0] awaddr = 6'h0, araddr = 6'h0;
    logic [31:0] wdata = 32'h0, rdata, mem_rdata, d;
    logic [3:0] wstrb = 4'hf, dev_addr;
    logic [1:0] bresp, rresp, baud_code, rr;
    logic [16:0] mem_addr, wr_ptr1 = 17'h1, wr_ptr2 = 17'h0, copy_first, copy_last;
    logic [8:1] module_present = 8'h0;
    logic [7:0] ser_data;
    int err_count = 0, tests_run = 0;
    pod_dispatcher i_dut (.*);
    pod_conn_model i_mdl (.*);
    always #5 aclk = ~aclk;
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    // write: both halves offered, each dropped once taken, then the response
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        logic ka, kw;
        ka = 1'h0;
        kw = 1'h0;
        awaddr <= a; wdata <= v; awvalid <= 1'h1; wvalid <= 1'h1;
        while (!(ka && kw)) begin
            @(negedge aclk) ka |= awready; kw |= wready;
            @(posedge aclk) awvalid <= !ka; wvalid <= !kw;
        end
        do @(negedge aclk); while (!bvalid);
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        araddr <= a; arvalid <= 1'h1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk) arvalid <= 1'h0;
        do @(negedge aclk); while (!rvalid);
        d = rdata; rr = rresp;
        @(posedge aclk);
    endtask : rd
    task automatic lf; // wait for a line end on the link
        while (!(i_mdl.q.size() > 1 && i_mdl.q[$] == 8'h0a)) @(posedge aclk);
    endtask : lf
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    initial begin // watchdog, far beyond the expected run
        #200000 err_count++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`POD_REG_STATUS); chk(d, 32'h0);
        rd(6'h3c); chk(rr, `POD_RESP_SLVERR);
        $display("test reset done");
        conn_busy <= 1'h1;
        wr(`POD_REG_CTRL, 32'h1201); wr(`POD_REG_CTRL, 32'h1201);
        rd(`POD_REG_STATUS); chk(d[7:4], 32'h1);
        chk(i_mdl.q.size(), 32'h0);
        conn_busy <= 1'h0;
        lf();
        chk({i_mdl.q[0], i_mdl.q[1], i_mdl.q[2]}, 32'h30312b);
        chk({i_mdl.q[3], i_mdl.q[4], i_mdl.q[5], i_mdl.q[6]}, 32'h31323334);
        chk({i_mdl.q[$-2], i_mdl.q[$-1]}, 32'h200d);
        $display("test queue done");
        i_mdl.q.delete(); slow <= 1'h0; wr_ptr1 <= 17'h3;
        wr(`POD_REG_CTRL, 32'h4301);
        do @(negedge aclk); while (!ser_valid);
        chk(addressing_enable_line, 32'h1);
        chk(baud_code, 32'h3);
        lf();
        $display("test pin printer done");
        i_mdl.q.delete();
        wr(`POD_REG_CTRL, 32'h7701);
        repeat (30) @(posedge aclk);
        rd(`POD_REG_STATUS); chk(d[7:4], 32'h0);
        rd(`POD_REG_MPTR); chk(d, 32'h0);
        rd(`POD_REG_PRINTER_OUTPUT_POINTER); chk(d, 32'h3);
        chk(i_mdl.q.size(), 32'h0);
        wr(`POD_REG_DCFG, 32'h8000);
        rd(`POD_REG_STATUS); chk(d[`POD_ST_REJECT], 32'h1);
        $display("test absent and reject done");
        finish_test();
    end
endmodule : pod_dispatcher_tb
